// *** shared/pic_pkg.sv ***
// Constants and types of the prioritized interrupt controller
package pic_pkg;
  localparam int N_SRC = 10;
  localparam int N_EXT = 7;
  localparam int N_SYNC = 8;
  localparam int SYNC_NMI = 7;
  // Source slots in fixed overall order
  localparam logic [3:0] SRC_TMR = 4'h0;
  localparam logic [3:0] SRC_DMA0 = 4'h1;
  localparam logic [3:0] SRC_DMA1 = 4'h2;
  localparam logic [3:0] SRC_EXT0 = 4'h3;
  localparam logic [3:0] SRC_EXT1 = 4'h4;
  localparam logic [3:0] SRC_EXT2 = 4'h5;
  localparam logic [3:0] SRC_EXT3 = 4'h6;
  localparam logic [3:0] SRC_EXT4 = 4'h7;
  localparam logic [3:0] SRC_SER1 = 4'h8;
  localparam logic [3:0] SRC_SER0 = 4'h9;
  // Type codes
  localparam logic [7:0] TYPE_TRACE = 8'h01;
  localparam logic [7:0] TYPE_NMI = 8'h02;
  localparam logic [7:0] TYPE_TMR0 = 8'h08;
  localparam logic [7:0] TYPE_TMR1 = 8'h12;
  localparam logic [7:0] TYPE_TMR2 = 8'h13;
  localparam logic [7:0] TYPE_DMA0 = 8'h0a;
  localparam logic [7:0] TYPE_DMA1 = 8'h0b;
  localparam logic [7:0] TYPE_EXT0 = 8'h0c;
  localparam logic [7:0] TYPE_SER1 = 8'h11;
  localparam logic [7:0] TYPE_SER0 = 8'h14;
  localparam logic [7:0] EOI_TMR = 8'h08;
  // Low type bits of timer and DMA sources in slave mode
  localparam logic [2:0] SLV_TMR0 = 3'h0;
  localparam logic [2:0] SLV_DMA0 = 3'h2;
  localparam logic [2:0] SLV_DMA1 = 3'h3;
  localparam logic [2:0] SLV_TMR1 = 3'h4;
  localparam logic [2:0] SLV_TMR2 = 3'h5;
  // Vector table
  localparam logic [9:0] VEC_BASE = 10'h000;
  localparam logic [1:0] VEC_PAD = 2'h0;
  // Register indices
  localparam logic [4:0] REG_CTL0 = 5'h00;
  localparam logic [4:0] REG_CTL_LAST = 5'h09;
  localparam logic [4:0] REG_MASK = 5'h0a;
  localparam logic [4:0] REG_INSVC = 5'h0b;
  localparam logic [4:0] REG_PEND = 5'h0c;
  localparam logic [4:0] REG_EOI = 5'h0d;
  localparam logic [4:0] REG_RELOC = 5'h0e;
  localparam logic [4:0] REG_SLV_BASE = 5'h0f;
  localparam logic [4:0] REG_STATUS = 5'h10;
  // Field positions
  localparam int RELOC_SLAVE_BIT = 14;
  localparam int STATUS_REQ_BIT = 15;
  localparam int STATUS_EXT_BIT = 14;
  localparam int PEND_TMR_LSB = 10;
  localparam int CTL_W = 7;
  localparam logic [2:0] PRIO_RESET = 3'h7;
  typedef struct packed {
    logic sfnm;
    logic cascade;
    logic level;
    logic mask;
    logic [2:0] prio;
  } pic_ctl_t;
  localparam pic_ctl_t CTL_RESET = '{1'b0, 1'b0, 1'b0, 1'b1, PRIO_RESET};
  typedef enum logic [2:0] {
    KIND_NONE, KIND_EXC, KIND_NMI, KIND_SW, KIND_MASK
  } pic_kind_t;
  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } pic_bus_t;
  typedef struct packed {
    logic req;
    logic ext;
    logic maskable;
    logic [7:0] itype;
    logic [9:0] vec;
  } pic_intr_t;
endpackage

// *** hw/pic_sync.sv ***
// Two-stage synchronizer for the interrupt pins
`timescale 1ns/1ns
module pic_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pins in, synchronized levels out
  input wire logic [pic_pkg::N_SYNC-1:0] pin,
  output logic [pic_pkg::N_SYNC-1:0] lvl
);
  typedef struct packed {
    logic [pic_pkg::N_SYNC-1:0] meta;
    logic [pic_pkg::N_SYNC-1:0] sync;
  } pic_sync_state_t;
  pic_sync_state_t q;
  pic_sync_state_t d;
  always_comb begin
    d.meta = pin;
    d.sync = q.meta;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign lvl = q.sync;
endmodule

// *** hw/pic_arb.sv ***
// Priority arbiter over the maskable source slots
`timescale 1ns/1ns
module pic_arb (
  // Eligible sources and their settings
  input wire logic [pic_pkg::N_SRC-1:0] elig,
  input wire pic_pkg::pic_ctl_t [pic_pkg::N_SRC-1:0] ctl,
  // Winner
  output logic found,
  output logic [3:0] win
);
  logic [2:0] best;
  always_comb begin
    found = 1'b0;
    win = 4'h0;
    best = pic_pkg::PRIO_RESET;
    for (int i = 0; i < pic_pkg::N_SRC; i++) begin
      // Level first, lower slot wins a tie
      if (elig[i] && (!found || ctl[i].prio < best)) begin // RULE_24
        found = 1'b1;
        win = 4'(i);
        best = ctl[i].prio;
      end
    end
  end
endmodule

// *** hw/pic_top.sv ***
// Prioritized interrupt controller top level
//
// What this block does
// (RULE_01) Present one prioritized request at a time
// (RULE_02) Pins 5, 6 usable when DMA allows
// (RULE_03) Pins 0-4 edge or level; 5, 6 edge
// (RULE_04) Cascade turns pins 2, 3 into acknowledges
// (RULE_05) Software ranks input 0 above input 1
// (RULE_06) Slave mode drops inputs 4 to 6
// (RULE_07) Equal or higher priority may preempt service
// (RULE_08) In-service source cannot request again
// (RULE_09) Fully nested option bypasses own in-service
// (RULE_10) Every interrupt has an 8-bit type
// (RULE_11) External controller supplies cascaded, slave types
// (RULE_12) Vector address is type shifted by two
// (RULE_13) Types 08h-1Fh maskable, 00h-07h not
// (RULE_14) Enable flag low holds off maskable requests
// (RULE_15) Per-source mask plus combined mask register
// (RULE_16) Combined mask written only while disabled; the block accepts the write whatever the enable flag
// (RULE_17) Priority fields reset to level seven
// (RULE_18) Nonmaskable always beats maskable
// (RULE_19) Software interrupt reaches any type unmasked
// (RULE_20) Fixed type code for each maskable source
// (RULE_21) Timers share one slot, ordered 0, 1, 2
// (RULE_22) Default order by fixed slot sequence
// (RULE_23) Slave mode programs timer and DMA types
// (RULE_24) Level 0 most urgent, slot breaks ties
// (RULE_25) Level request held until acknowledged
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ns
module pic_top (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Register port
  input wire pic_pkg::pic_bus_t BUS,
  output logic [15:0] RDATA,
  // Interrupt pins, pins 2 and 3 double as acknowledges
  input wire logic [pic_pkg::N_EXT-1:0] EXT_REQ_IN,
  input wire logic NMI_IN,
  output logic [1:0] CASCADE_ACK_N_OUT,
  output logic [1:0] CASCADE_ACK_OE,
  // Internal peripheral sources
  input wire logic [2:0] TMR_REQ,
  input wire logic [1:0] DMA_REQ,
  input wire logic [1:0] SER_REQ,
  // DMA channel state
  input wire logic [1:0] DMA_EN,
  input wire logic [1:0] DMA_INT_SYNC,
  // Processor core
  input wire logic CPU_IE,
  input wire logic EXC_REQ,
  input wire logic [2:0] EXC_TYPE,
  input wire logic SW_REQ,
  input wire logic [7:0] SW_TYPE,
  input wire logic INT_ACK,
  output pic_pkg::pic_intr_t INTR
);
  typedef struct packed {
    pic_pkg::pic_ctl_t [pic_pkg::N_SRC-1:0] ctl;
    logic [pic_pkg::N_SRC-1:0] insvc;
    logic [pic_pkg::N_SRC-1:0] pend;
    logic [2:0] tmr_pend;
    logic nmi_pend;
    logic nmi_prev;
    logic exc_pend;
    logic [2:0] exc_type;
    logic sw_pend;
    logic [7:0] sw_type;
    logic slave;
    logic [7:0] slv_base;
    logic [pic_pkg::N_EXT-1:0] ext_prev;
    pic_pkg::pic_kind_t kind;
    logic [3:0] idx;
    logic [1:0] tsub;
    pic_pkg::pic_intr_t intr;
    logic [1:0] cack;
    logic [15:0] rdata;
  } pic_state_t;

  pic_state_t q;
  pic_state_t d;
  logic [pic_pkg::N_SYNC-1:0] pin_lvl;
  logic [pic_pkg::N_SRC-1:0] elig;
  logic found;
  logic [3:0] win;

  function automatic logic [7:0] type_of(input logic [3:0] s,
      input logic [1:0] t, input logic slv, input logic [7:0] base);
    logic [7:0] ty;
    logic [2:0] lo;
    ty = pic_pkg::TYPE_EXT0 + 8'(s - pic_pkg::SRC_EXT0); // RULE_20
    lo = pic_pkg::SLV_TMR0;
    case (s)
      pic_pkg::SRC_TMR: begin // RULE_21
        ty = (t == 2'h0) ? pic_pkg::TYPE_TMR0 :
             (t == 2'h1) ? pic_pkg::TYPE_TMR1 : pic_pkg::TYPE_TMR2;
        lo = (t == 2'h0) ? pic_pkg::SLV_TMR0 :
             (t == 2'h1) ? pic_pkg::SLV_TMR1 : pic_pkg::SLV_TMR2;
      end
      pic_pkg::SRC_DMA0: begin
        ty = pic_pkg::TYPE_DMA0;
        lo = pic_pkg::SLV_DMA0;
      end
      pic_pkg::SRC_DMA1: begin
        ty = pic_pkg::TYPE_DMA1;
        lo = pic_pkg::SLV_DMA1;
      end
      pic_pkg::SRC_SER1: ty = pic_pkg::TYPE_SER1;
      pic_pkg::SRC_SER0: ty = pic_pkg::TYPE_SER0;
      default: ;
    endcase
    if (slv && s <= pic_pkg::SRC_DMA1) begin
      ty = {base[7:3], lo}; // RULE_23
    end
    return ty;
  endfunction

  pic_sync u_sync (
    .clk(CLOCK),
    .rst_n(RST_N),
    .pin({NMI_IN, EXT_REQ_IN}),
    .lvl(pin_lvl)
  );

  pic_arb u_arb (
    .elig(elig),
    .ctl(q.ctl),
    .found(found),
    .win(win)
  );

  logic [pic_pkg::N_SRC-1:0] avail;
  logic [pic_pkg::N_SRC-1:0] set;
  logic [pic_pkg::N_SRC-1:0] clr;
  logic [pic_pkg::N_SRC-1:0] eoi_clr;
  logic [pic_pkg::N_SRC-1:0] mask_v;
  logic [pic_pkg::N_EXT-1:0] rise;
  logic [2:0] tclr;
  logic [3:0] floor;
  logic taken;
  logic use5;
  logic use6;
  logic sfnm_ok;
  logic [7:0] ty;

  // Availability, preemption floor and eligibility
  always_comb begin
    avail = '1;
    use5 = (~DMA_EN[0] | DMA_INT_SYNC[0]) & ~q.slave; // RULE_02
    use6 = (~DMA_EN[1] | DMA_INT_SYNC[1]) & ~q.slave; // RULE_06
    if (q.ctl[pic_pkg::SRC_EXT0].cascade) begin
      avail[pic_pkg::SRC_EXT2] = 1'b0; // RULE_04
    end
    if (q.ctl[pic_pkg::SRC_EXT1].cascade) begin
      avail[pic_pkg::SRC_EXT3] = 1'b0; // RULE_04
    end
    if (q.slave) begin
      avail[pic_pkg::SRC_EXT4] = 1'b0; // RULE_06
      avail[pic_pkg::SRC_SER1] = 1'b0; // RULE_23
      avail[pic_pkg::SRC_SER0] = 1'b0;
    end
    floor = 4'h8;
    sfnm_ok = 1'b0;
    elig = '0;
    for (int i = 0; i < pic_pkg::N_SRC; i++) begin
      if (q.insvc[i] && {1'b0, q.ctl[i].prio} < floor) begin
        floor = {1'b0, q.ctl[i].prio};
      end
    end
    for (int i = 0; i < pic_pkg::N_SRC; i++) begin
      sfnm_ok = q.ctl[i].sfnm &&
        (i == pic_pkg::SRC_EXT0 || i == pic_pkg::SRC_EXT1); // RULE_09
      elig[i] = q.pend[i] & avail[i] & ~q.ctl[i].mask & CPU_IE & // RULE_14
        (~q.insvc[i] | sfnm_ok) & // RULE_08
        ({1'b0, q.ctl[i].prio} <= floor); // RULE_07
    end
  end

  always_comb begin
    d = q;
    d.rdata = 16'h0000;
    d.cack = 2'b00;
    clr = '0;
    tclr = 3'h0;
    eoi_clr = '0;
    mask_v = '0;
    ty = 8'h00;
    // Request capture
    rise = pin_lvl[pic_pkg::N_EXT-1:0] & ~q.ext_prev;
    d.ext_prev = pin_lvl[pic_pkg::N_EXT-1:0];
    set = '0;
    set[pic_pkg::SRC_TMR] = |TMR_REQ;
    set[pic_pkg::SRC_DMA0] = DMA_REQ[0] | (use5 & rise[5]); // RULE_03
    set[pic_pkg::SRC_DMA1] = DMA_REQ[1] | (use6 & rise[6]);
    for (int i = 0; i < 5; i++) begin
      set[pic_pkg::SRC_EXT0 + i] = rise[i];
    end
    set[pic_pkg::SRC_SER1] = SER_REQ[1];
    set[pic_pkg::SRC_SER0] = SER_REQ[0];
    set = set & avail;
    // Acknowledge of the presented request
    taken = INT_ACK & q.intr.req; // RULE_01
    if (taken) begin
      unique case (q.kind)
        pic_pkg::KIND_EXC: d.exc_pend = 1'b0;
        pic_pkg::KIND_NMI: d.nmi_pend = 1'b0;
        pic_pkg::KIND_SW: d.sw_pend = 1'b0;
        pic_pkg::KIND_MASK: begin
          clr[q.idx] = 1'b1;
          tclr[q.tsub] = (q.idx == pic_pkg::SRC_TMR);
          if (q.idx == pic_pkg::SRC_EXT0 && q.intr.ext) begin
            d.cack[0] = 1'b1; // RULE_04
          end
          if (q.idx == pic_pkg::SRC_EXT1 && q.intr.ext) begin
            d.cack[1] = 1'b1;
          end
        end
        pic_pkg::KIND_NONE: ;
      endcase
    end
    // Nonmaskable capture, set wins over clear
    if (EXC_REQ) begin
      d.exc_pend = 1'b1;
      d.exc_type = EXC_TYPE;
    end
    if (pin_lvl[pic_pkg::SYNC_NMI] && !q.nmi_prev) begin
      d.nmi_pend = 1'b1;
    end
    d.nmi_prev = pin_lvl[pic_pkg::SYNC_NMI];
    if (SW_REQ) begin
      d.sw_pend = 1'b1; // RULE_19
      d.sw_type = SW_TYPE;
    end
    d.tmr_pend = (q.tmr_pend & ~tclr) | TMR_REQ; // RULE_21
    d.pend = (q.pend & ~clr) | set;
    d.pend[pic_pkg::SRC_TMR] = |d.tmr_pend;
    for (int i = 0; i < 5; i++) begin
      if (q.ctl[pic_pkg::SRC_EXT0 + i].level) begin
        d.pend[pic_pkg::SRC_EXT0 + i] = pin_lvl[i] &
          avail[pic_pkg::SRC_EXT0 + i]; // RULE_25
      end
    end
    // Register writes
    if (BUS.wr) begin
      if (BUS.addr <= pic_pkg::REG_CTL_LAST) begin
        d.ctl[BUS.addr[3:0]] =
          pic_pkg::pic_ctl_t'(BUS.wdata[pic_pkg::CTL_W-1:0]); // RULE_15
      end else begin
        case (BUS.addr)
          pic_pkg::REG_MASK: begin
            for (int i = 0; i < pic_pkg::N_SRC; i++) begin
              d.ctl[i].mask = BUS.wdata[i]; // RULE_15
            end
          end
          pic_pkg::REG_EOI: begin
            for (int i = 0; i < pic_pkg::N_SRC; i++) begin
              eoi_clr[i] = (i == 0) ? BUS.wdata[7:0] == pic_pkg::EOI_TMR :
                BUS.wdata[7:0] == type_of(4'(i), 2'h0, 1'b0, 8'h00);
            end
          end
          pic_pkg::REG_RELOC: d.slave = BUS.wdata[pic_pkg::RELOC_SLAVE_BIT];
          pic_pkg::REG_SLV_BASE: d.slv_base = BUS.wdata[7:0];
          default: ;
        endcase
      end
    end
    // In-service: acknowledge sets, end of service clears
    d.insvc = (q.insvc & ~eoi_clr) | clr; // RULE_08
    // Register reads, data in the next cycle
    for (int i = 0; i < pic_pkg::N_SRC; i++) begin
      mask_v[i] = q.ctl[i].mask;
    end
    if (BUS.rd) begin
      if (BUS.addr <= pic_pkg::REG_CTL_LAST) begin
        d.rdata = 16'(q.ctl[BUS.addr[3:0]]);
      end else begin
        case (BUS.addr)
          pic_pkg::REG_MASK: d.rdata = 16'(mask_v);
          pic_pkg::REG_INSVC: d.rdata = 16'(q.insvc);
          pic_pkg::REG_PEND: d.rdata = 16'({q.tmr_pend, q.pend});
          pic_pkg::REG_RELOC: d.rdata[pic_pkg::RELOC_SLAVE_BIT] = q.slave;
          pic_pkg::REG_SLV_BASE: d.rdata = {8'h00, q.slv_base};
          pic_pkg::REG_STATUS: begin
            d.rdata[7:0] = q.intr.itype;
            d.rdata[pic_pkg::STATUS_REQ_BIT] = q.intr.req;
            d.rdata[pic_pkg::STATUS_EXT_BIT] = q.intr.ext;
          end
          default: ;
        endcase
      end
    end
    // Presentation, nonmaskable ahead of maskable
    d.intr.maskable = 1'b0;
    d.intr.ext = 1'b0;
    d.intr.req = 1'b1;
    if (taken) begin
      d.intr.req = 1'b0;
      d.kind = pic_pkg::KIND_NONE;
    end else if (q.exc_pend && {5'h00, q.exc_type} == pic_pkg::TYPE_TRACE) begin
      d.kind = pic_pkg::KIND_EXC; // RULE_18
      ty = pic_pkg::TYPE_TRACE;
    end else if (q.nmi_pend) begin
      d.kind = pic_pkg::KIND_NMI;
      ty = pic_pkg::TYPE_NMI;
    end else if (q.exc_pend) begin
      d.kind = pic_pkg::KIND_EXC; // RULE_13
      ty = {5'h00, q.exc_type};
    end else if (q.sw_pend) begin
      d.kind = pic_pkg::KIND_SW;
      ty = q.sw_type;
    end else if (found) begin
      d.kind = pic_pkg::KIND_MASK; // RULE_22
      d.idx = win;
      d.tsub = q.tmr_pend[0] ? 2'h0 : q.tmr_pend[1] ? 2'h1 : 2'h2;
      ty = type_of(win, d.tsub, q.slave, q.slv_base); // RULE_10
      d.intr.maskable = 1'b1;
      d.intr.ext = (win == pic_pkg::SRC_EXT0 || win == pic_pkg::SRC_EXT1)
        ? q.ctl[win].cascade
        : q.slave && win >= pic_pkg::SRC_EXT0; // RULE_11
    end else begin
      d.intr.req = 1'b0;
      d.kind = pic_pkg::KIND_NONE;
    end
    d.intr.itype = ty;
    d.intr.vec = pic_pkg::VEC_BASE | {ty, pic_pkg::VEC_PAD}; // RULE_12
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      q <= '0;
      q.ctl <= {pic_pkg::N_SRC{pic_pkg::CTL_RESET}}; // RULE_17
      q.kind <= pic_pkg::KIND_NONE;
    end else begin
      q <= d;
    end
  end

  assign RDATA = q.rdata;
  assign INTR = q.intr;
  assign CASCADE_ACK_N_OUT = ~q.cack;
  assign CASCADE_ACK_OE = {q.ctl[pic_pkg::SRC_EXT1].cascade,
    q.ctl[pic_pkg::SRC_EXT0].cascade};
endmodule

// *** sim/pic_assertions.sv ***
// Concurrent checks on the interrupt controller ports
`timescale 1ns/1ns
module pic_assertions (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Watched ports
  input wire pic_pkg::pic_bus_t BUS,
  input wire logic [15:0] RDATA,
  input wire logic [1:0] CASCADE_ACK_N_OUT,
  input wire logic [1:0] CASCADE_ACK_OE,
  input wire logic CPU_IE,
  input wire logic INT_ACK,
  input wire pic_pkg::pic_intr_t INTR
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);
  // Slave mode tracked from relocation writes
  logic slv_q;
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      slv_q <= 1'b0;
    end else if (BUS.wr && BUS.addr == pic_pkg::REG_RELOC) begin
      slv_q <= BUS.wdata[pic_pkg::RELOC_SLAVE_BIT];
    end
  end
  AST_VEC: assert property (
    INTR.req |-> INTR.vec == {INTR.itype, 2'h0})
    else $error("Vector is not type times four");
  AST_MTYPE: assert property (
    INTR.req && INTR.maskable && !INTR.ext && !slv_q && !$past(slv_q)
      |-> INTR.itype inside {[8'h08:8'h1f]})
    else $error("Maskable request outside maskable types");
  AST_IE: assert property (
    INTR.req && INTR.maskable |-> $past(CPU_IE))
    else $error("Maskable request with enable flag low");
  AST_ONE: assert property (
    INT_ACK && INTR.req |=> !INTR.req)
    else $error("Request still shown after acknowledge");
  AST_CACK: assert property (
    $fell(CASCADE_ACK_N_OUT[0]) |-> $past(INT_ACK && INTR.req && INTR.ext))
    else $error("Cascade acknowledge without taken request");
  AST_CPULSE: assert property (
    !CASCADE_ACK_N_OUT[0] |=> CASCADE_ACK_N_OUT[0])
    else $error("Cascade acknowledge longer than one cycle");
  AST_COE: assert property (
    (~CASCADE_ACK_N_OUT & ~CASCADE_ACK_OE) == 2'h0)
    else $error("Acknowledge low on an undriven pin");
  AST_RDZ: assert property (
    !$past(BUS.rd) |-> RDATA == 16'h0000)
    else $error("Read data outside the read cycle");
endmodule
bind pic_top pic_assertions u_chk (
  .CLOCK(CLOCK),
  .RST_N(RST_N),
  .BUS(BUS),
  .RDATA(RDATA),
  .CASCADE_ACK_N_OUT(CASCADE_ACK_N_OUT),
  .CASCADE_ACK_OE(CASCADE_ACK_OE),
  .CPU_IE(CPU_IE),
  .INT_ACK(INT_ACK),
  .INTR(INTR)
);

// *** sim/pic_cpu_model.sv ***
// Processor core model that takes presented interrupts
`timescale 1ns/1ns
module pic_cpu_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Interrupt handshake
  input wire pic_pkg::pic_intr_t intr,
  output logic ack,
  // Answer delay and enable flag commands
  input wire logic [3:0] lat,
  input wire logic [1:0] ie_cmd,
  // Enable flag and last taken request
  output logic ie,
  output pic_pkg::pic_intr_t got,
  output logic took
);
  logic [3:0] cnt_q;
  logic take_now;
  assign take_now = ack && intr.req;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      ack <= 1'b0;
      ie <= 1'b0;
      got <= '0;
      took <= 1'b0;
    end else begin
      cnt_q <= (intr.req && !ack) ? cnt_q + 4'h1 : 4'h0;
      ack <= intr.req && !ack && cnt_q >= lat;
      took <= take_now;
      if (take_now)
        got <= intr;
      if (take_now)
        ie <= 1'b0;
      else if (ie_cmd[0])
        ie <= 1'b1;
      else if (ie_cmd[1])
        ie <= 1'b0;
    end
  end
endmodule

// *** sim/tb.sv ***
// Self-checking bench of the interrupt controller
`timescale 1ns/1ns
module tb;
  logic CLOCK, RST_N, nmi, ack, ie, took, sw, exc;
  pic_pkg::pic_bus_t bus;
  pic_pkg::pic_intr_t intr, got;
  logic [15:0] rdata;
  logic [6:0] ext;
  logic [2:0] tmr, exct;
  logic [1:0] dma, ser, den, ie_cmd, oe, ack_n, dsync, ack_seen;
  logic [7:0] swt;
  logic [3:0] lat;
  int err_count, check_count;
  pic_top u_dut (.CLOCK(CLOCK), .RST_N(RST_N), .BUS(bus), .RDATA(rdata),
    .EXT_REQ_IN(ext), .NMI_IN(nmi), .CASCADE_ACK_N_OUT(ack_n),
    .CASCADE_ACK_OE(oe), .TMR_REQ(tmr), .DMA_REQ(dma), .SER_REQ(ser),
    .DMA_EN(den), .DMA_INT_SYNC(dsync), .CPU_IE(ie), .EXC_REQ(exc),
    .EXC_TYPE(exct), .SW_REQ(sw), .SW_TYPE(swt), .INT_ACK(ack),
    .INTR(intr));
  pic_cpu_model u_cpu (.clk(CLOCK), .rst_n(RST_N), .intr(intr), .ack(ack),
    .lat(lat), .ie_cmd(ie_cmd), .ie(ie), .got(got), .took(took));
  initial begin
    CLOCK = 1'b0;
    forever #25 CLOCK = ~CLOCK;
  end
  task complete_run;
    $display("Checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task cmp(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [4:0] a, input logic [15:0] v);
    bus.addr <= a;
    bus.wdata <= v;
    bus.wr <= 1'b1;
    @(posedge CLOCK);
    bus.wr <= 1'b0;
    @(posedge CLOCK);
  endtask
  task rd(input logic [4:0] a, input logic [15:0] e);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge CLOCK);
    bus.rd <= 1'b0;
    @(negedge CLOCK);
    cmp(rdata, e);
    @(posedge CLOCK);
  endtask
  task setie(input logic [1:0] c);
    ie_cmd <= c;
    @(posedge CLOCK);
    ie_cmd <= 2'h0;
  endtask
  task wait_take;
    int n;
    n = 0;
    do begin
      @(negedge CLOCK);
      n++;
    end while (took !== 1'b1 && n < 60);
    ack_seen = ack_n;
    cmp({15'h0, n < 60}, 16'h0001);
    @(posedge CLOCK);
  endtask
  task take(input logic [9:0] e);
    wait_take();
    cmp({6'h0, got.ext, got.maskable, got.itype}, {6'h0, e});
  endtask
  task none(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(negedge CLOCK);
      seen = seen | took;
    end
    cmp({15'h0, seen}, 16'h0000);
    @(posedge CLOCK);
  endtask
  initial begin
    #100000;
    err_count++;
    complete_run();
  end
  initial begin
    RST_N = 1'b0;
    bus = '0;
    {ext, nmi, tmr, dma, ser, den, ie_cmd, sw, swt, lat, dsync} = '0;
    {exc, exct} = '0;
    ack_seen = 2'h3;
    repeat (6) @(posedge CLOCK);
    RST_N <= 1'b1;
    @(posedge CLOCK);
    rd(pic_pkg::REG_CTL0, 16'h000f);
    rd(pic_pkg::REG_CTL_LAST, 16'h000f);
    rd(pic_pkg::REG_MASK, 16'h03ff);
    rd(5'h1f, 16'h0000);
    $display("Test reset values done");
    wr(pic_pkg::REG_CTL0, 16'h0003);
    setie(2'h1);
    tmr <= 3'b110;
    @(posedge CLOCK);
    tmr <= 3'h0;
    take(10'h112);
    cmp({14'h0, ack_seen}, 16'h0003);
    setie(2'h1);
    none(10);
    rd(pic_pkg::REG_INSVC, 16'h0001);
    wr(pic_pkg::REG_EOI, 16'h0008);
    take(10'h113);
    wr(pic_pkg::REG_EOI, 16'h0008);
    $display("Test timers done");
    wr(5'h02, 16'h0002);
    wr(5'h09, 16'h0001);
    dma <= 2'b10;
    ser <= 2'b01;
    @(posedge CLOCK);
    dma <= 2'h0;
    ser <= 2'h0;
    none(8);
    setie(2'h1);
    take(10'h114);
    wr(pic_pkg::REG_EOI, 16'h0014);
    setie(2'h1);
    take(10'h10b);
    wr(pic_pkg::REG_EOI, 16'h000b);
    $display("Test priority done");
    wr(pic_pkg::REG_MASK, 16'h03ff);
    rd(pic_pkg::REG_CTL0, 16'h000b);
    dma <= 2'b10;
    @(posedge CLOCK);
    dma <= 2'h0;
    setie(2'h1);
    none(8);
    setie(2'h2);
    wr(pic_pkg::REG_MASK, 16'h0000);
    setie(2'h1);
    take(10'h10b);
    wr(pic_pkg::REG_EOI, 16'h000b);
    $display("Test mask done");
    lat <= 4'h6;
    setie(2'h1);
    nmi <= 1'b1;
    tmr <= 3'b001;
    @(posedge CLOCK);
    tmr <= 3'h0;
    take(10'h002);
    setie(2'h1);
    take(10'h108);
    wr(pic_pkg::REG_EOI, 16'h0008);
    nmi <= 1'b0;
    lat <= 4'h0;
    sw <= 1'b1;
    swt <= 8'hff;
    @(posedge CLOCK);
    sw <= 1'b0;
    take(10'h0ff);
    lat <= 4'h6;
    nmi <= 1'b1;
    exc <= 1'b1;
    exct <= 3'h1;
    @(posedge CLOCK);
    exc <= 1'b0;
    take(10'h001);
    take(10'h002);
    nmi <= 1'b0;
    lat <= 4'h0;
    $display("Test nonmaskable done");
    wr(5'h03, 16'h0020);
    @(negedge CLOCK);
    cmp({14'h0, oe}, 16'h0001);
    @(posedge CLOCK);
    setie(2'h1);
    ext[0] <= 1'b1;
    wait_take();
    cmp({15'h0, got.ext}, 16'h0001);
    cmp({14'h0, ack_seen}, 16'h0002);
    ext[0] <= 1'b0;
    wr(5'h03, 16'h0060);
    setie(2'h1);
    ext[0] <= 1'b1;
    take(10'h30c);
    cmp({14'h0, ack_seen}, 16'h0002);
    ext[0] <= 1'b0;
    wr(pic_pkg::REG_EOI, 16'h000c);
    $display("Test cascade done");
    den <= 2'b01;
    ext[5] <= 1'b1;
    setie(2'h1);
    none(10);
    ext[5] <= 1'b0;
    den <= 2'h0;
    repeat (4) @(posedge CLOCK);
    ext[5] <= 1'b1;
    take(10'h10a);
    wr(pic_pkg::REG_EOI, 16'h000a);
    setie(2'h1);
    none(10);
    ext[5] <= 1'b0;
    repeat (4) @(posedge CLOCK);
    den <= 2'b01;
    dsync <= 2'b01;
    ext[5] <= 1'b1;
    take(10'h10a);
    ext[5] <= 1'b0;
    wr(pic_pkg::REG_EOI, 16'h000a);
    $display("Test shared pin done");
    wr(5'h07, 16'h0010);
    setie(2'h1);
    ext[4] <= 1'b1;
    take(10'h110);
    setie(2'h1);
    none(8);
    ext[4] <= 1'b0;
    repeat (4) @(posedge CLOCK);
    wr(pic_pkg::REG_EOI, 16'h0010);
    none(8);
    $display("Test level done");
    wr(pic_pkg::REG_RELOC, 16'h4000);
    rd(pic_pkg::REG_RELOC, 16'h4000);
    wr(pic_pkg::REG_SLV_BASE, 16'h0020);
    setie(2'h1);
    tmr <= 3'b001;
    ser <= 2'b01;
    @(posedge CLOCK);
    tmr <= 3'h0;
    ser <= 2'h0;
    take(10'h120);
    wr(pic_pkg::REG_EOI, 16'h0008);
    setie(2'h1);
    none(8);
    wr(pic_pkg::REG_RELOC, 16'h0000);
    $display("Test slave done");
    complete_run();
  end
endmodule
